/* shared/cdro_regs.vh */
// Constants for the current detection and remote output block
`ifndef CDRO_REGS_VH
`define CDRO_REGS_VH

// Parameter numbers used as register indexes on the parameter port
`define CDRO_NUM_OC_LEVEL      10'h096
`define CDRO_NUM_OC_DELAY      10'h097
`define CDRO_NUM_ZC_LEVEL      10'h098
`define CDRO_NUM_ZC_TIME       10'h099
`define CDRO_NUM_TERM_FUNC0    10'h0be
`define CDRO_NUM_TERM_FUNC1    10'h0bf
`define CDRO_NUM_TERM_FUNC2    10'h0c0
`define CDRO_NUM_WRITE_PROT    10'h04d
`define CDRO_NUM_RETAIN_SEL    10'h1ef
`define CDRO_NUM_WORD_ONE      10'h1f0
`define CDRO_NUM_WORD_TWO      10'h1f1

// Reset values
`define CDRO_RST_OC_LEVEL      8'h96
`define CDRO_RST_OC_DELAY      8'h00
`define CDRO_RST_ZC_LEVEL      8'h05
`define CDRO_RST_ZC_TIME       8'h32
`define CDRO_RST_TERM_FUNC0    8'h00
`define CDRO_RST_TERM_FUNC1    8'h04
`define CDRO_RST_TERM_FUNC2    8'h63
`define CDRO_RST_WRITE_PROT    8'h00
`define CDRO_RST_RETAIN_SEL    4'h0

// Setting limits
`define CDRO_MAX_OC_LEVEL      8'h78
`define CDRO_MAX_OC_DELAY      8'h64
`define CDRO_MAX_ZC_LEVEL      8'hc8
`define CDRO_MAX_ZC_TIME       8'h64
`define CDRO_MAX_WRITE_PROT    8'h02

// Retention selection codes
`define CDRO_SEL_CLR_CLR       4'h0
`define CDRO_SEL_KEEP_CLR      4'h1
`define CDRO_SEL_CLR_KEEP      4'ha
`define CDRO_SEL_KEEP_KEEP     4'hb

// Terminal function codes
`define CDRO_FN_OC_POS         8'h0c
`define CDRO_FN_OC_NEG         8'h70
`define CDRO_FN_ZC_POS         8'h0d
`define CDRO_FN_ZC_NEG         8'h71
`define CDRO_FN_RMT_POS        8'h60
`define CDRO_FN_RMT_NEG        8'hc4

// Remote word bit layout and read masks
`define CDRO_W1_RELAY_LSB      4
`define CDRO_W1_USED_MASK      12'h077
`define CDRO_W2_USED_MASK      12'h07f

// Timing
`define CDRO_CLK_NS            4
`define CDRO_TICK_NS           1000000
`define CDRO_HOLD_MS           16'h0064
`define CDRO_OC_DELAY_MS_STEP  16'h0064
`define CDRO_ZC_TIME_MS_STEP   16'h000a

`endif

/* src/cdro_persist.v */
// Persistence timer and minimum-on hold for one current comparison
module cdro_persist
(
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire        tick_in,
  input  wire        qual_in,
  input  wire [15:0] limit_ms_in,
  input  wire [15:0] hold_ms_in,
  output reg         flag_out
);

  reg [15:0] cnt_q;
  reg [15:0] hold_q;
  wire       det;

  // Condition has held for longer than the limit
  assign det = qual_in && (cnt_q > limit_ms_in);

  // Count ticks while qualified, restart on any break
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cnt_q <= 16'h0000;
    else if (!qual_in)
      cnt_q <= 16'h0000;
    else if (tick_in && !det)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Hold the flag for the minimum on time after detection ends
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hold_q   <= 16'h0000;
      flag_out <= 1'b0;
    end
    else
    begin
      if (det)
        hold_q <= hold_ms_in;
      else if (tick_in && hold_q != 16'h0000)
        hold_q <= hold_q - 16'h0001;
      flag_out <= det || (hold_q != 16'h0000);
    end
  end

endmodule

/* src/cdro_top.v */
// Current detection flags and remote-driven output terminals
// Operation
// - Overcurrent flag after level exceeded beyond delay
// - Overcurrent flag held on about 100 ms
// - Overcurrent level in percent, 0 to 120
// - Zero-current flag after low current beyond time
// - Zero-current flag held on 100 ms
// - Zero level of zero disables detection
// - Overcurrent flag on codes 12 and 112
// - Zero-current flag on codes 13 and 113
// - Detection stays active during online auto tuning
// - Zero-current defaults: 5 percent, 0.5 s
// - Remote function on codes 96 and 196
// - Remote bit drives terminal, sink inverts
// - Two remote words, 0 to 4095
// - Word one bit 0 drives running terminal
// - Non-remote terminals ignore remote bits
// - Selection 0 or 10: power loss clears words
// - Selection 1 or 11: save at power-off
// - Inverter reset: clear, restore, or keep words
// - Remote words writable regardless of write protection
// - Unused remote bits always read zero
// - Option terminal bits need option fitted
`include "cdro_regs.vh"

module cdro_top
#(
  parameter TICK_CYCLES = `CDRO_TICK_NS / `CDRO_CLK_NS
)
(
  input  wire        sys_clk_in,
  input  wire        arst_n_in,
  input  wire [7:0]  current_pct_in,
  input  wire        running_in,
  input  wire        autotune_in,
  input  wire        inv_reset_in,
  input  wire        power_fail_in,
  input  wire        ext_fitted_in,
  input  wire        relay_fitted_in,
  input  wire [2:0]  assigned_func_in,
  input  wire        par_wr_in,
  input  wire        par_rd_in,
  input  wire [9:0]  par_num_in,
  input  wire [15:0] par_wdata_in,
  output reg  [15:0] par_rdata_out,
  output reg         par_ack_out,
  output reg         par_err_out,
  input  wire        nvm_load_in,
  input  wire [3:0]  nvm_sel_in,
  input  wire [11:0] nvm_word_one_in,
  input  wire [11:0] nvm_word_two_in,
  output reg         nvm_save_out,
  output reg  [3:0]  nvm_sel_out,
  output reg  [11:0] nvm_word_one_out,
  output reg  [11:0] nvm_word_two_out,
  output reg         overcurrent_detect_flag_out,
  output reg         zero_current_flag_out,
  output reg  [2:0]  term_out,
  output reg  [6:0]  ext_term_out,
  output reg  [2:0]  relay_term_out
);

  localparam [17:0] TICK_LAST = TICK_CYCLES[17:0] - 18'h0_0001;
  localparam        NSYNC     = 6;

  // Synchronised pin inputs
  wire [NSYNC-1:0] pin_raw;
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  reg              inv_reset_d1_q;
  reg              power_fail_d1_q;
  wire             running_s;
  wire             autotune_s;
  wire             inv_reset_s;
  wire             power_fail_s;
  wire             ext_fitted_s;
  wire             relay_fitted_s;
  wire             inv_reset_rise;
  wire             power_fail_rise;
  wire             run_act;

  // Settings
  reg  [7:0]  oc_level_q;
  reg  [7:0]  oc_delay_q;
  reg  [7:0]  zc_level_q;
  reg  [7:0]  zc_time_q;
  reg  [7:0]  term_func_q [0:2];
  reg  [7:0]  write_prot_q;
  reg  [3:0]  retain_sel_q;
  reg  [11:0] word_one_q;
  reg  [11:0] word_two_q;

  // Tick and detection
  reg  [17:0] tick_cnt_q;
  reg         tick_q;
  wire [15:0] oc_limit_ms;
  wire [15:0] zc_limit_ms;
  wire        oc_cond;
  wire        zc_cond;
  wire        oc_flag;
  wire        zc_flag;

  // Parameter port decode
  reg         in_range;
  reg         known;
  reg         is_remote;
  reg  [15:0] rd_val;
  wire        prot_ok;
  wire        wr_ok;

  assign pin_raw = {relay_fitted_in, ext_fitted_in, power_fail_in,
                    inv_reset_in, autotune_in, running_in};

  // Two-stage synchronisers for the six pins in pin_raw
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  assign running_s      = sync2_q[0];
  assign autotune_s     = sync2_q[1];
  assign inv_reset_s    = sync2_q[2];
  assign power_fail_s   = sync2_q[3];
  assign ext_fitted_s   = sync2_q[4];
  assign relay_fitted_s = sync2_q[5];

  // Edge detection of reset and power-fail events
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      inv_reset_d1_q  <= 1'b0;
      power_fail_d1_q <= 1'b0;
    end
    else
    begin
      inv_reset_d1_q  <= inv_reset_s;
      power_fail_d1_q <= power_fail_s;
    end
  end

  assign inv_reset_rise  = inv_reset_s && !inv_reset_d1_q;
  assign power_fail_rise = power_fail_s && !power_fail_d1_q;

  // Auto tuning counts as operation, so detection stays live
  assign run_act = running_s | autotune_s;

  // One millisecond tick
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tick_cnt_q <= 18'h0_0000;
      tick_q     <= 1'b0;
    end
    else if (tick_cnt_q == TICK_LAST)
    begin
      tick_cnt_q <= 18'h0_0000;
      tick_q     <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 18'h0_0001;
      tick_q     <= 1'b0;
    end
  end

  // Comparisons against the percent-of-rated levels
  assign oc_cond = run_act && (current_pct_in > oc_level_q);
  assign zc_cond = run_act && (zc_level_q != 8'h00)
                   && (current_pct_in < zc_level_q);
  assign oc_limit_ms = oc_delay_q * `CDRO_OC_DELAY_MS_STEP;
  assign zc_limit_ms = zc_time_q * `CDRO_ZC_TIME_MS_STEP;

  cdro_persist u_oc_persist
  (
    .clk_in      (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (tick_q),
    .qual_in     (oc_cond),
    .limit_ms_in (oc_limit_ms),
    .hold_ms_in  (`CDRO_HOLD_MS),
    .flag_out    (oc_flag)
  );

  cdro_persist u_zc_persist
  (
    .clk_in      (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (tick_q),
    .qual_in     (zc_cond),
    .limit_ms_in (zc_limit_ms),
    .hold_ms_in  (`CDRO_HOLD_MS),
    .flag_out    (zc_flag)
  );

  // Decode of the parameter number, range check and readback
  always @*
  begin
    known     = 1'b1;
    in_range  = 1'b1;
    is_remote = 1'b0;
    rd_val    = 16'h0000;
    case (par_num_in)
      `CDRO_NUM_OC_LEVEL:
      begin
        rd_val   = {8'h00, oc_level_q};
        in_range = par_wdata_in <= {8'h00, `CDRO_MAX_OC_LEVEL};
      end
      `CDRO_NUM_OC_DELAY:
      begin
        rd_val   = {8'h00, oc_delay_q};
        in_range = par_wdata_in <= {8'h00, `CDRO_MAX_OC_DELAY};
      end
      `CDRO_NUM_ZC_LEVEL:
      begin
        rd_val   = {8'h00, zc_level_q};
        in_range = par_wdata_in <= {8'h00, `CDRO_MAX_ZC_LEVEL};
      end
      `CDRO_NUM_ZC_TIME:
      begin
        rd_val   = {8'h00, zc_time_q};
        in_range = par_wdata_in <= {8'h00, `CDRO_MAX_ZC_TIME};
      end
      `CDRO_NUM_TERM_FUNC0: rd_val = {8'h00, term_func_q[0]};
      `CDRO_NUM_TERM_FUNC1: rd_val = {8'h00, term_func_q[1]};
      `CDRO_NUM_TERM_FUNC2: rd_val = {8'h00, term_func_q[2]};
      `CDRO_NUM_WRITE_PROT:
      begin
        rd_val   = {8'h00, write_prot_q};
        in_range = par_wdata_in <= {8'h00, `CDRO_MAX_WRITE_PROT};
      end
      `CDRO_NUM_RETAIN_SEL:
      begin
        rd_val   = {12'h000, retain_sel_q};
        in_range = (par_wdata_in == {12'h000, `CDRO_SEL_CLR_CLR})
                || (par_wdata_in == {12'h000, `CDRO_SEL_KEEP_CLR})
                || (par_wdata_in == {12'h000, `CDRO_SEL_CLR_KEEP})
                || (par_wdata_in == {12'h000, `CDRO_SEL_KEEP_KEEP});
      end
      `CDRO_NUM_WORD_ONE:
      begin
        is_remote = 1'b1;
        rd_val    = {4'h0, word_one_q & `CDRO_W1_USED_MASK};
        in_range  = par_wdata_in[15:12] == 4'h0;
      end
      `CDRO_NUM_WORD_TWO:
      begin
        is_remote = 1'b1;
        rd_val    = {4'h0, word_two_q & `CDRO_W2_USED_MASK};
        in_range  = par_wdata_in[15:12] == 4'h0;
      end
      default:
      begin
        known    = 1'b0;
        in_range = 1'b0;
      end
    endcase
  end

  // Write protection: 0 stopped only, 1 locked, 2 always; write protection number and remote words exempt
  assign prot_ok = is_remote
                || (par_num_in == `CDRO_NUM_WRITE_PROT)
                || (write_prot_q == 8'h02)
                || (write_prot_q == 8'h00 && !run_act);
  assign wr_ok   = par_wr_in && known && in_range && prot_ok;

  // Parameter port answer one cycle after the request
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      par_ack_out   <= 1'b0;
      par_err_out   <= 1'b0;
      par_rdata_out <= 16'h0000;
    end
    else
    begin
      par_ack_out   <= par_wr_in || par_rd_in;
      par_err_out   <= (par_wr_in && !wr_ok) || (par_rd_in && !known);
      par_rdata_out <= par_rd_in ? rd_val : 16'h0000;
    end
  end

  // Detection, terminal function and write protection settings
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      oc_level_q     <= `CDRO_RST_OC_LEVEL;
      oc_delay_q     <= `CDRO_RST_OC_DELAY;
      zc_level_q     <= `CDRO_RST_ZC_LEVEL;
      zc_time_q      <= `CDRO_RST_ZC_TIME;
      term_func_q[0] <= `CDRO_RST_TERM_FUNC0;
      term_func_q[1] <= `CDRO_RST_TERM_FUNC1;
      term_func_q[2] <= `CDRO_RST_TERM_FUNC2;
      write_prot_q   <= `CDRO_RST_WRITE_PROT;
    end
    else if (wr_ok)
    begin
      case (par_num_in)
        `CDRO_NUM_OC_LEVEL:   oc_level_q     <= par_wdata_in[7:0];
        `CDRO_NUM_OC_DELAY:   oc_delay_q     <= par_wdata_in[7:0];
        `CDRO_NUM_ZC_LEVEL:   zc_level_q     <= par_wdata_in[7:0];
        `CDRO_NUM_ZC_TIME:    zc_time_q      <= par_wdata_in[7:0];
        `CDRO_NUM_TERM_FUNC0: term_func_q[0] <= par_wdata_in[7:0];
        `CDRO_NUM_TERM_FUNC1: term_func_q[1] <= par_wdata_in[7:0];
        `CDRO_NUM_TERM_FUNC2: term_func_q[2] <= par_wdata_in[7:0];
        `CDRO_NUM_WRITE_PROT: write_prot_q   <= par_wdata_in[7:0];
        default:              write_prot_q   <= write_prot_q;
      endcase
    end
  end

  // Remote words: power-on clear, restore, inverter reset and host writes
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      retain_sel_q <= `CDRO_RST_RETAIN_SEL;
      word_one_q   <= 12'h000;
      word_two_q   <= 12'h000;
    end
    else if (nvm_load_in)
    begin
      retain_sel_q <= nvm_sel_in;
      if (nvm_sel_in == `CDRO_SEL_KEEP_CLR || nvm_sel_in == `CDRO_SEL_KEEP_KEEP)
      begin
        word_one_q <= nvm_word_one_in;
        word_two_q <= nvm_word_two_in;
      end
    end
    else if (inv_reset_rise)
    begin
      case (retain_sel_q)
        `CDRO_SEL_CLR_CLR:
        begin
          word_one_q <= 12'h000;
          word_two_q <= 12'h000;
        end
        `CDRO_SEL_KEEP_CLR:
        begin
          word_one_q <= nvm_word_one_out;
          word_two_q <= nvm_word_two_out;
        end
        default:
          word_one_q <= word_one_q;
      endcase
    end
    else if (wr_ok)
    begin
      if (par_num_in == `CDRO_NUM_RETAIN_SEL)
        retain_sel_q <= par_wdata_in[3:0];
      if (par_num_in == `CDRO_NUM_WORD_ONE)
        word_one_q <= par_wdata_in[11:0];
      if (par_num_in == `CDRO_NUM_WORD_TWO)
        word_two_q <= par_wdata_in[11:0];
    end
  end

  // Save to nonvolatile memory on power-off only, never on inverter reset
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nvm_save_out     <= 1'b0;
      nvm_sel_out      <= `CDRO_RST_RETAIN_SEL;
      nvm_word_one_out <= 12'h000;
      nvm_word_two_out <= 12'h000;
    end
    else if (nvm_load_in)
    begin
      nvm_save_out     <= 1'b0;
      nvm_sel_out      <= nvm_sel_in;
      nvm_word_one_out <= nvm_word_one_in;
      nvm_word_two_out <= nvm_word_two_in;
    end
    else if (power_fail_rise)
    begin
      nvm_save_out <= 1'b1;
      nvm_sel_out  <= retain_sel_q;
      if (retain_sel_q == `CDRO_SEL_KEEP_CLR || retain_sel_q == `CDRO_SEL_KEEP_KEEP)
      begin
        nvm_word_one_out <= word_one_q;
        nvm_word_two_out <= word_two_q;
      end
      else
      begin
        nvm_word_one_out <= 12'h000;
        nvm_word_two_out <= 12'h000;
      end
    end
    else
      nvm_save_out <= 1'b0;
  end

  // Level of one base terminal from its function code
  function term_level;
    input [7:0] code;
    input       oc;
    input       zc;
    input       rmt;
    input       other;
    begin
      case (code)
        `CDRO_FN_OC_POS:  term_level = oc;
        `CDRO_FN_OC_NEG:  term_level = !oc;
        `CDRO_FN_ZC_POS:  term_level = zc;
        `CDRO_FN_ZC_NEG:  term_level = !zc;
        `CDRO_FN_RMT_POS: term_level = rmt;
        `CDRO_FN_RMT_NEG: term_level = !rmt;
        default:          term_level = other;
      endcase
    end
  endfunction

  // Registered terminal and flag outputs
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      overcurrent_detect_flag_out <= 1'b0;
      zero_current_flag_out       <= 1'b0;
      term_out                    <= 3'h0;
      ext_term_out                <= 7'h00;
      relay_term_out              <= 3'h0;
    end
    else
    begin
      overcurrent_detect_flag_out <= oc_flag;
      zero_current_flag_out       <= zc_flag;
      term_out[0] <= term_level(term_func_q[0], oc_flag, zc_flag,
                                word_one_q[0], assigned_func_in[0]);
      term_out[1] <= term_level(term_func_q[1], oc_flag, zc_flag,
                                word_one_q[1], assigned_func_in[1]);
      term_out[2] <= term_level(term_func_q[2], oc_flag, zc_flag,
                                word_one_q[2], assigned_func_in[2]);
      ext_term_out   <= ext_fitted_s ? word_two_q[6:0] : 7'h00;
      relay_term_out <= relay_fitted_s ?
                        word_one_q[`CDRO_W1_RELAY_LSB+2:`CDRO_W1_RELAY_LSB] :
                        3'h0;
    end
  end

endmodule

/* bench/cdro_top_sva.sv */
// Port assertions for the current detection and remote output block
`include "cdro_regs.vh"
module cdro_top_sva
#(
  parameter TICK_CYCLES = 10
)
(
  input wire        sys_clk_in,
  input wire        arst_n_in,
  input wire        par_wr_in,
  input wire        par_rd_in,
  input wire [9:0]  par_num_in,
  input wire [15:0] par_rdata_out,
  input wire        par_ack_out,
  input wire        par_err_out,
  input wire        nvm_save_out,
  input wire        overcurrent_detect_flag_out,
  input wire        zero_current_flag_out,
  input wire        ext_fitted_in,
  input wire        relay_fitted_in,
  input wire [6:0]  ext_term_out,
  input wire [2:0]  relay_term_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence rd_of(logic [9:0] n);
    par_ack_out && $past(par_rd_in) && ($past(par_num_in) == n);
  endsequence
  // Parameter port handshake
  a_ack_follows_req: assert property ((par_wr_in || par_rd_in) |=> par_ack_out)
    else $error("no answer one cycle after a request");
  a_ack_has_cause: assert property (par_ack_out |-> $past(par_wr_in || par_rd_in))
    else $error("answer without a request");
  a_ack_one_cycle: assert property (par_ack_out && !par_wr_in && !par_rd_in |=> !par_ack_out)
    else $error("answer stands longer than one cycle");
  a_rdata_idle_zero: assert property (!par_ack_out |-> par_rdata_out == 16'h0000)
    else $error("read data not zero outside an answer");
  a_err_with_ack: assert property (par_err_out |-> par_ack_out)
    else $error("refusal without answer");
  // Unused remote bits read as zero
  a_word_one_mask: assert property (rd_of(`CDRO_NUM_WORD_ONE) |-> (par_rdata_out & 16'hff88) == 0)
    else $error("unused bit of word one read as one");
  a_word_two_mask: assert property (rd_of(`CDRO_NUM_WORD_TWO) |-> (par_rdata_out & 16'hff80) == 0)
    else $error("unused bit of word two read as one");
  // Minimum on time of both flags
  a_oc_min_hold: assert property ($rose(overcurrent_detect_flag_out) |-> overcurrent_detect_flag_out [*8])
    else $error("overcurrent flag dropped early");
  a_zc_min_hold: assert property ($rose(zero_current_flag_out) |-> zero_current_flag_out [*8])
    else $error("zero current flag dropped early");
  // Option terminals stay off without the option
  a_ext_unfitted: assert property ((!ext_fitted_in) [*6] |-> ext_term_out == 7'h00)
    else $error("extension terminal driven without option");
  a_relay_unfitted: assert property ((!relay_fitted_in) [*6] |-> relay_term_out == 3'h0)
    else $error("relay terminal driven without option");
  a_save_one_cycle: assert property ($rose(nvm_save_out) |=> !nvm_save_out)
    else $error("save pulse longer than one cycle");
  c_oc_flag: cover property ($rose(overcurrent_detect_flag_out));
  c_zc_flag: cover property ($rose(zero_current_flag_out));
  c_save: cover property (nvm_save_out);
endmodule

bind cdro_top cdro_top_sva #(.TICK_CYCLES(TICK_CYCLES)) cdro_top_sva_inst
(
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .par_wr_in(par_wr_in),
  .par_rd_in(par_rd_in), .par_num_in(par_num_in), .par_rdata_out(par_rdata_out),
  .par_ack_out(par_ack_out), .par_err_out(par_err_out), .nvm_save_out(nvm_save_out),
  .overcurrent_detect_flag_out(overcurrent_detect_flag_out),
  .zero_current_flag_out(zero_current_flag_out), .ext_fitted_in(ext_fitted_in),
  .relay_fitted_in(relay_fitted_in), .ext_term_out(ext_term_out),
  .relay_term_out(relay_term_out)
);

/* bench/cdro_host_model.sv */
// Host model that reads and writes parameters over the parameter port
module cdro_host_model
(
  input  wire         clk_in,
  input  wire         ack_in,
  input  wire         err_in,
  input  wire  [15:0] rdata_in,
  output logic        wr_out,
  output logic        rd_out,
  output logic [9:0]  num_out,
  output logic [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_out = 0;
    rd_out = 0;
    num_out = 10'h000;
    wdata_out = 16'h0000;
  end
  // One access: request for one edge, then wait a bounded time for the answer
  task automatic access(input logic w, input logic [9:0] n, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic ok);
    ok = 0;
    q = 16'h0000;
    e = 0;
    @(negedge clk_in);
    wr_out = w;
    rd_out = !w;
    num_out = n;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 0;
    rd_out = 0;
    num_out = ~n;  // Released lines show the inverse, not the old value
    wdata_out = ~d;
    for (int i = 0; i < 3 && !ok; i++)
    begin
      if (ack_in === 1'b1)
      begin
        ok = 1;
        q = rdata_in;
        e = err_in;
      end
      else
        @(negedge clk_in);
    end
  endtask
endmodule

/* bench/tb_cdro_top.sv */
// Self-checking testbench for the current detection and remote output block
`include "cdro_regs.vh"
module tb_cdro_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam TICK = 10;
  localparam [9:0] OL = `CDRO_NUM_OC_LEVEL, OD = `CDRO_NUM_OC_DELAY;
  localparam [9:0] ZL = `CDRO_NUM_ZC_LEVEL, ZT = `CDRO_NUM_ZC_TIME, RS = `CDRO_NUM_RETAIN_SEL;
  localparam [9:0] F0 = `CDRO_NUM_TERM_FUNC0, F1 = `CDRO_NUM_TERM_FUNC1;
  localparam [9:0] F2 = `CDRO_NUM_TERM_FUNC2, W1 = `CDRO_NUM_WORD_ONE, W2 = `CDRO_NUM_WORD_TWO;
  logic        sys_clk_in = 0;
  logic        arst_n_in = 0;
  logic [7:0]  cur = 8'h00;
  logic        run = 0, tune = 0, inv_rst = 0, pfail = 0, ext_fit = 0, rel_fit = 0, nload = 0;
  logic [2:0]  asg = 3'b100;
  wire         wr, rd, ack, err_o, save, oc, zc;
  wire  [9:0]  num;
  wire  [15:0] wdata, rdata;
  wire  [11:0] nw1, nw2;
  wire  [3:0]  nsel;
  wire  [2:0]  term, relay;
  wire  [6:0]  ext;
  int          errors = 0;
  int          n_checks = 0;
  int          i;
  logic [15:0] rmt_w [3] = '{16'h0001, 16'h0003, 16'h0004};
  logic [2:0]  rmt_t [3] = '{3'b111, 3'b101, 3'b110};
  logic [15:0] sel_c [4] = '{16'h0000, 16'h0001, 16'h000a, 16'h000b};
  logic [15:0] inv_e [4] = '{16'h0000, 16'h0055, 16'h0003, 16'h0003};
  always #2 sys_clk_in = ~sys_clk_in;
  cdro_top #(.TICK_CYCLES(TICK)) cdro_top_inst
  (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .current_pct_in(cur),
    .running_in(run), .autotune_in(tune), .inv_reset_in(inv_rst), .power_fail_in(pfail),
    .ext_fitted_in(ext_fit), .relay_fitted_in(rel_fit), .assigned_func_in(asg),
    .par_wr_in(wr), .par_rd_in(rd), .par_num_in(num), .par_wdata_in(wdata),
    .par_rdata_out(rdata), .par_ack_out(ack), .par_err_out(err_o), .nvm_load_in(nload),
    .nvm_sel_in(4'hb), .nvm_word_one_in(12'h0e6), .nvm_word_two_in(12'h05a),
    .nvm_save_out(save), .nvm_sel_out(nsel), .nvm_word_one_out(nw1), .nvm_word_two_out(nw2),
    .overcurrent_detect_flag_out(oc), .zero_current_flag_out(zc), .term_out(term),
    .ext_term_out(ext), .relay_term_out(relay)
  );
  cdro_host_model cdro_host_model_inst
  (
    .clk_in(sys_clk_in), .ack_in(ack), .err_in(err_o), .rdata_in(rdata),
    .wr_out(wr), .rd_out(rd), .num_out(num), .wdata_out(wdata)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One parameter access with its expected answer; a missing answer ends the run
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d,
                     input logic [15:0] exp, input logic exp_err);
    logic [15:0] q;
    logic        e, ok;
    cdro_host_model_inst.access(w, a, d, q, e, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      complete_run();
    end
    check({15'h0000, e}, {15'h0000, exp_err});
    if (!w)
      check(q, exp);
  endtask
  task automatic put(input logic [9:0] a, input logic [15:0] d, input logic e);
    acc(1'b1, a, d, 16'h0000, e);
  endtask
  task automatic get(input logic [9:0] a, input logic [15:0] exp, input logic e);
    acc(1'b0, a, 16'h0000, exp, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask
  // Bounded wait for a flag to reach a level; running out ends the run
  task automatic wait_flag(input logic [1:0] sel, input logic lvl, input int max);
    int k = 0;
    while ((((sel == 2'h2) ? save : (sel[0] ? zc : oc)) !== lvl) && k < max)
    begin
      cyc(1);
      k++;
    end
    if (k == max)
    begin
      errors++;
      complete_run();
    end
  endtask
  initial
  begin
    cyc(8);
    arst_n_in = 1;
    cyc(2);
    // Reset values, unmapped number and setting limits
    get(ZL, 16'h0005, 0);
    get(ZT, 16'h0032, 0);
    get(RS, 16'h0000, 0);
    get(W2, 16'h0000, 0);
    get(10'h001, 16'h0000, 1);
    put(OL, 16'h0079, 1);
    put(OL, 16'h0078, 0);
    get(OL, 16'h0078, 0);
    put(OD, 16'h0065, 1);
    put(ZL, 16'h00c9, 1);
    put(ZT, 16'h0065, 1);
    put(RS, 16'h0002, 1);
    put(W1, 16'h1000, 1);
    put(W1, 16'h0fff, 0);
    get(W1, 16'h0077, 0);
    put(W2, 16'h0fff, 0);
    get(W2, 16'h007f, 0);
    $display("test settings done");
    // Remote terminals: source, sink and one with another function
    put(F0, 16'h0060, 0);
    put(F1, 16'h00c4, 0);
    put(F2, 16'h0004, 0);
    for (i = 0; i < 3; i++)
    begin
      put(W1, rmt_w[i], 0);
      cyc(2);
      check({13'h0000, term}, {13'h0000, rmt_t[i]});
    end
    put(W1, 16'h0070, 0);
    put(W2, 16'h0055, 0);
    cyc(8);
    check({13'h0000, relay}, 16'h0000);
    check({9'h000, ext}, 16'h0000);
    ext_fit = 1;
    rel_fit = 1;
    cyc(8);
    check({13'h0000, relay}, 16'h0007);
    check({9'h000, ext}, 16'h0055);
    run = 1;
    cyc(6);
    put(W1, 16'h0000, 0);
    put(OL, 16'h0032, 1);
    run = 0;
    cyc(6);
    $display("test remote outputs done");
    // Overcurrent flag: zero delay, hold time, then restart of the delay
    put(F0, 16'h000c, 0);
    put(OL, 16'h0032, 0);
    cur = 8'h64;
    run = 1;
    wait_flag(0, 1, 40);
    cyc(3);
    check({15'h0000, term[0]}, 16'h0001);
    cur = 8'h00;
    cyc(900);
    check({15'h0000, oc}, 16'h0001);
    wait_flag(0, 0, 200);
    run = 0;
    cyc(6);
    put(F0, 16'h0070, 0);
    cyc(3);
    check({15'h0000, term[0]}, 16'h0001);
    put(OD, 16'h0001, 0);
    run = 1;
    cur = 8'h64;
    cyc(600);
    cur = 8'h00;
    cyc(30);
    cur = 8'h64;
    cyc(600);
    check({15'h0000, oc}, 16'h0000);
    wait_flag(0, 1, 600);
    cur = 8'h00;
    run = 0;
    cyc(6);
    $display("test overcurrent done");
    // Zero current flag: disabled by level zero, then under auto tuning
    put(F1, 16'h0071, 0);
    put(F2, 16'h000d, 0);
    put(ZT, 16'h0000, 0);
    put(ZL, 16'h0000, 0);
    run = 1;
    cyc(100);
    check({15'h0000, zc}, 16'h0000);
    run = 0;
    cyc(6);
    put(ZL, 16'h0005, 0);
    tune = 1;
    wait_flag(1, 1, 40);
    cyc(3);
    check({14'h0000, term[2:1]}, 16'h0002);
    tune = 0;
    cyc(900);
    check({15'h0000, zc}, 16'h0001);
    wait_flag(1, 0, 200);
    $display("test zero current done");
    // Retention codes: save at power off, then inverter reset
    for (i = 0; i < 4; i++)
    begin
      put(RS, sel_c[i], 0);
      put(W1, 16'h0055, 0);
      put(W2, 16'h002a, 0);
      pfail = 1;
      wait_flag(2, 1, 10);
      cyc(1);
      check({12'h000, nsel}, sel_c[i]);
      check({4'h0, nw1}, sel_c[i][0] ? 16'h0055 : 16'h0000);
      check({4'h0, nw2}, sel_c[i][0] ? 16'h002a : 16'h0000);
      pfail = 0;
      put(W1, 16'h0003, 0);
      inv_rst = 1;
      cyc(6);
      inv_rst = 0;
      cyc(2);
      get(W1, inv_e[i], 0);
    end
    nload = 1;
    cyc(1);
    nload = 0;
    check({12'h000, nsel}, 16'h000b);
    get(RS, 16'h000b, 0);
    get(W1, 16'h0066, 0);
    $display("test retention done");
    complete_run();
  end
endmodule
